/* rtl/cs0_cfg.svh */
// Constants of the space-0 external bus sequencer: register indices,
// field positions, reset values and master numbers.
// Assumes it is included by bare name from files under rtl/ and from the bench files.
`ifndef CS0_CFG_SVH
`define CS0_CFG_SVH

// ==========================================================================
// Register indices on the plain register port
`define REG_WAIT_CFG 4'h0
`define REG_IDLE_CFG 4'h1
`define REG_STATUS 4'h2

// ==========================================================================
// Field positions
`define WAIT_LSB 0
`define IW_LSB 8
`define CW_BIT 4
`define SW_BIT 0

// ==========================================================================
// Reset values and reserved bits that read as ones
`define WAIT_FIELD_RST 4'hf
`define RW_IDLE_RST 2'h3
`define CONT_IDLE_RST 1'b1
`define ASSERT_EXT_RST 1'b1
`define WCFG_RSVD 16'hfff0
`define ICFG_RSVD 16'hfcee

// ==========================================================================
// Internal master numbers and idle counter ceiling
`define MST_CPU 2'h0
`define MST_XFER 2'h1
`define MST_TRACE 2'h2
`define IDLE_SAT 3'h4

`endif

/* rtl/cs0_pkg.sv */
// Types shared by the space-0 external bus sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package cs0_pkg;

  // ========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    st_idle,
    st_lead,
    st_t1,
    st_tw,
    st_t2,
    st_trail,
    st_released,
    st_rejoin
  } seq_state_t;

endpackage

/* rtl/bus_priority_arbiter.sv */
// Fixed-priority selection of the external bus owner.
// Assumes requests are synchronous levels on the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "cs0_cfg.svh"

module bus_priority_arbiter #(
  parameter bit TRACE_PRESENT = 1'b1
) (
  input wire logic ext_req,
  input wire logic [2:0] mst_req,
  output logic ext_win,
  output logic mst_win,
  output logic [1:0] mst_idx
);

  // ========================================================================
  // Priority decode
  wire logic trace_req;
  assign trace_req = mst_req[`MST_TRACE] & TRACE_PRESENT; // RL17
  assign ext_win = ext_req; // RL15
  assign mst_win = trace_req | mst_req[`MST_XFER] | mst_req[`MST_CPU];
  assign mst_idx = trace_req ? `MST_TRACE :
                   mst_req[`MST_XFER] ? `MST_XFER : `MST_CPU; // RL15

endmodule // bus_priority_arbiter

`default_nettype wire

/* rtl/cs0_config_regs.sv */
// Wait and idle configuration registers with a status read port.
// Assumes one-cycle strobes; read data stand only in the next cycle.
`timescale 1ns/1ps
`default_nettype none
`include "cs0_cfg.svh"

module cs0_config_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] status,
  output logic [15:0] reg_rdata,
  output logic [3:0] wait_count,
  output logic [1:0] rw_idle,
  output logic cont_idle,
  output logic assert_ext
);

  // ========================================================================
  // Decode
  wire logic wr_wait;
  wire logic wr_idle;
  wire logic [15:0] wait_word;
  wire logic [15:0] idle_word;
  wire logic [15:0] rd_word;
  assign wr_wait = reg_wr & (reg_addr == `REG_WAIT_CFG);
  assign wr_idle = reg_wr & (reg_addr == `REG_IDLE_CFG);
  assign wait_word = `WCFG_RSVD | {12'h000, wait_count}; // RL2
  assign idle_word = `ICFG_RSVD | {6'h00, rw_idle, 3'h0, cont_idle,
                                   3'h0, assert_ext};
  assign rd_word = (reg_addr == `REG_WAIT_CFG) ? wait_word :
                   (reg_addr == `REG_IDLE_CFG) ? idle_word :
                   (reg_addr == `REG_STATUS) ? status : 16'h0000;

  // ========================================================================
  // Storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_count <= `WAIT_FIELD_RST;
    end else if (wr_wait) begin
      wait_count <= reg_wdata[`WAIT_LSB +: 4]; // RL1
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rw_idle <= `RW_IDLE_RST;
      cont_idle <= `CONT_IDLE_RST;
      assert_ext <= `ASSERT_EXT_RST;
    end else if (wr_idle) begin
      rw_idle <= reg_wdata[`IW_LSB +: 2]; // RL18
      cont_idle <= reg_wdata[`CW_BIT]; // RL19
      assert_ext <= reg_wdata[`SW_BIT]; // RL20
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_word : 16'h0000;
    end
  end

endmodule // cs0_config_regs

`default_nettype wire

/* rtl/external_cs0_bus_timing.sv */
// Space-0 external bus sequencer with wait, idle and release control.
// Assumes all inputs are synchronous to clk; pins are resolved outside.
`timescale 1ns/1ps
`default_nettype none
`include "cs0_cfg.svh"

// How it works
// RL1 - Four-bit wait field gives 0..15 waits; zero disables the stall input.
// RL2 - Wait register bits 15..4 read as ones; software writes ones.
// RL3 - Without waits or extension an access takes exactly two states.
// RL4 - Reads capture the whole eight-bit data bus while read strobe asserted.
// RL5 - Writes assert the low-byte write strobe for data bits 7..0.
// RL6 - Software wait states sit between first and second basic states.
// RL7 - Stall input sampled one edge before last wait moves to second state.
// RL8 - Software using stall sets one wait with extension, two otherwise.
// RL9 - Extension adds leading and trailing states with only chip select.
// RL10 - With extension, write data stays driven through the trailing state.
// RL11 - Write after read gets read-to-write idle cycles, only the shortfall.
// RL12 - Back-to-back accesses get continuous idle, negating chip select once.
// RL13 - Write after read uses larger of read-write and continuous idle.
// RL14 - No continuous idle is inserted when idle cycles already exist.
// RL15 - Priority: external requester, trace master, transfer unit, processor.
// RL16 - External master requests by low request; device acknowledges low.
// RL17 - Three internal masters; the trace master exists on one variant.
// RL18 - Two-bit read-to-write idle field means zero to three idle cycles.
// RL19 - Continuous idle bit means none when clear, one when set.
// RL20 - Extension bit set adds one cycle before and after each access.
// RL21 - While acknowledged all bus pins float; drive resumes after negation.
// RL22 - Target holds stall low at sampling edge; each adds one wait.
module external_cs0_bus_timing #(
  parameter int AW = 16,
  parameter int DW = 8,
  parameter bit TRACE_PRESENT = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [2:0] mst_req,
  input wire logic [2:0] mst_we,
  input wire logic [3*AW-1:0] mst_addr,
  input wire logic [3*DW-1:0] mst_wdata,
  output var logic [2:0] mst_ack,
  output var logic [2:0] mst_done,
  output var logic [DW-1:0] mst_rdata,
  output var logic [AW-1:0] ext_addr,
  output var logic chip_select_space0_n,
  output var logic read_strobe_n,
  output var logic low_byte_write_strobe_n,
  output var logic pins_oe_n,
  input wire logic [DW-1:0] data_in,
  output var logic [DW-1:0] data_out,
  output var logic data_oe_n,
  input wire logic stall_n,
  input wire logic bus_request_n,
  output var logic bus_ack_n
);

  // ========================================================================
  // Helpers
  function automatic logic [1:0] max2(input logic [1:0] a,
                                      input logic [1:0] b);
    max2 = (a > b) ? a : b;
  endfunction

  function automatic logic [2:0] onehot3(input logic [1:0] idx);
    onehot3 = 3'h1 << idx;
  endfunction

  function automatic logic in_strobe(input cs0_pkg::seq_state_t s);
    in_strobe = (s == cs0_pkg::st_t1) || (s == cs0_pkg::st_tw) ||
                (s == cs0_pkg::st_t2);
  endfunction

  // ========================================================================
  // Configuration registers
  wire logic [3:0] wait_count;
  wire logic [1:0] rw_idle;
  wire logic cont_idle;
  wire logic assert_ext;
  wire logic [15:0] status;

  cs0_config_regs u_regs (
    .clk(clk),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .status(status),
    .reg_rdata(reg_rdata),
    .wait_count(wait_count),
    .rw_idle(rw_idle),
    .cont_idle(cont_idle),
    .assert_ext(assert_ext)
  );

  // ========================================================================
  // Arbitration
  wire logic ext_win;
  wire logic mst_win;
  wire logic [1:0] pick_idx;

  bus_priority_arbiter #(
    .TRACE_PRESENT(TRACE_PRESENT)
  ) u_arb (
    .ext_req(~bus_request_n),
    .mst_req(mst_req),
    .ext_win(ext_win),
    .mst_win(mst_win),
    .mst_idx(pick_idx)
  );

  // ========================================================================
  // State
  cs0_pkg::seq_state_t state_r;
  cs0_pkg::seq_state_t state_nxt;
  logic [3:0] wcnt_r;
  logic [3:0] wcnt_nxt;
  logic stall_hold_r;
  logic stall_hold_nxt;
  logic [2:0] idle_cnt_r;
  logic [2:0] idle_cnt_nxt;
  logic prev_read_r;
  logic [1:0] cur_idx_r;
  logic cur_we_r;
  logic launch;

  // ========================================================================
  // Selection and idle-gap decode
  wire logic sel_we;
  wire logic [AW-1:0] sel_addr;
  wire logic [DW-1:0] sel_wdata;
  wire logic wait_en;
  wire logic last_read;
  wire logic [1:0] rw_need;
  wire logic [1:0] need;
  wire logic [2:0] have;
  wire logic start_ok;
  wire logic we_nxt;
  wire logic strobe_nxt;
  wire logic cs_nxt;
  wire logic drive_nxt;
  wire logic float_nxt;
  wire logic leave_t2;

  assign sel_we = mst_we[pick_idx];
  assign sel_addr = mst_addr[pick_idx*AW +: AW];
  assign sel_wdata = mst_wdata[pick_idx*DW +: DW];
  assign wait_en = (wait_count != 4'h0); // RL1

  // A read still in its second basic state is the access before the next
  // one, since its own flag is only written as that state ends.
  assign last_read = (state_r == cs0_pkg::st_t2) ? ~cur_we_r :
                     prev_read_r; // RL11
  assign rw_need = (last_read & sel_we) ? rw_idle : 2'h0; // RL11

  assign need = max2(rw_need, {1'b0, cont_idle}); // RL13 RL12
  // Idle cycles already present, counting the current one.
  assign have = (state_r == cs0_pkg::st_idle) ? idle_cnt_r + 3'h1 : 3'h0;
  // A cycle of idle already covers the one continuous idle cycle.
  assign start_ok = mst_win & ~ext_win & ({1'b0, need} <= have); // RL14 RL11
  assign we_nxt = launch ? sel_we : cur_we_r;
  assign strobe_nxt = in_strobe(state_nxt);
  assign cs_nxt = strobe_nxt || (state_nxt == cs0_pkg::st_lead) ||
                  (state_nxt == cs0_pkg::st_trail); // RL9
  assign drive_nxt = (strobe_nxt & we_nxt) ||
                     ((state_nxt == cs0_pkg::st_trail) & cur_we_r); // RL10
  assign float_nxt = (state_nxt == cs0_pkg::st_released) ||
                     (state_nxt == cs0_pkg::st_rejoin); // RL21
  assign leave_t2 = (state_r == cs0_pkg::st_t2);
  assign status = {10'h000, ~bus_ack_n, cur_idx_r, state_r};

  // ========================================================================
  // Next-state logic
  always_comb begin
    state_nxt = state_r;
    wcnt_nxt = wcnt_r;
    stall_hold_nxt = stall_hold_r;
    launch = 1'b0;
    case (state_r)
      cs0_pkg::st_idle: begin
        if (ext_win) begin
          state_nxt = cs0_pkg::st_released; // RL16
        end else if (start_ok) begin
          launch = 1'b1;
        end
      end
      cs0_pkg::st_lead: begin
        state_nxt = cs0_pkg::st_t1; // RL9
      end
      cs0_pkg::st_t1: begin
        state_nxt = wait_en ? cs0_pkg::st_tw : cs0_pkg::st_t2; // RL3 RL6
        if (wait_count == 4'h1) begin
          stall_hold_nxt = ~stall_n; // RL7 RL8
        end
      end
      cs0_pkg::st_tw: begin
        if (wcnt_r == 4'h1) begin
          if (stall_hold_r) begin
            stall_hold_nxt = ~stall_n; // RL22
          end else begin
            state_nxt = cs0_pkg::st_t2; // RL6
          end
        end else begin
          wcnt_nxt = wcnt_r - 4'h1;
          if (wcnt_r == 4'h2) begin
            stall_hold_nxt = ~stall_n; // RL7
          end
        end
      end
      cs0_pkg::st_t2: begin
        if (assert_ext) begin
          state_nxt = cs0_pkg::st_trail; // RL9 RL20
        end else if (start_ok) begin
          launch = 1'b1; // RL3
        end else begin
          state_nxt = cs0_pkg::st_idle;
        end
      end
      cs0_pkg::st_trail: begin
        if (start_ok) begin
          launch = 1'b1;
        end else begin
          state_nxt = cs0_pkg::st_idle;
        end
      end
      cs0_pkg::st_released: begin
        if (bus_request_n) begin
          state_nxt = cs0_pkg::st_rejoin; // RL16 RL21
        end
      end
      cs0_pkg::st_rejoin: begin
        state_nxt = cs0_pkg::st_idle; // RL21
      end
      default: begin
        state_nxt = cs0_pkg::st_idle;
      end
    endcase
    if (launch) begin
      state_nxt = assert_ext ? cs0_pkg::st_lead : cs0_pkg::st_t1; // RL20
      wcnt_nxt = wait_count; // RL6
      stall_hold_nxt = 1'b0;
    end
  end

  // Counts completed idle cycles, saturating above any possible need.
  assign idle_cnt_nxt = (state_r != cs0_pkg::st_idle) ? 3'h0 :
                        (idle_cnt_r == `IDLE_SAT) ? idle_cnt_r :
                        idle_cnt_r + 3'h1;

  // ========================================================================
  // Sequencer registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= cs0_pkg::st_idle;
      wcnt_r <= 4'h0;
      stall_hold_r <= 1'b0;
      idle_cnt_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      wcnt_r <= wcnt_nxt;
      stall_hold_r <= stall_hold_nxt;
      idle_cnt_r <= idle_cnt_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cur_idx_r <= `MST_CPU;
      cur_we_r <= 1'b0;
      ext_addr <= '0;
      data_out <= '0;
    end else if (launch) begin
      cur_idx_r <= pick_idx;
      cur_we_r <= sel_we;
      ext_addr <= sel_addr;
      data_out <= sel_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_read_r <= 1'b0;
    end else if (leave_t2) begin
      prev_read_r <= ~cur_we_r; // RL11
    end
  end

  // ========================================================================
  // Master handshake
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mst_ack <= 3'h0;
      mst_done <= 3'h0;
    end else begin
      mst_ack <= launch ? onehot3(pick_idx) : 3'h0;
      mst_done <= leave_t2 ? onehot3(cur_idx_r) : 3'h0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mst_rdata <= '0;
    end else if (leave_t2 & ~cur_we_r) begin
      mst_rdata <= data_in; // RL4
    end
  end

  // ========================================================================
  // Pins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chip_select_space0_n <= 1'b1;
      read_strobe_n <= 1'b1;
      low_byte_write_strobe_n <= 1'b1;
    end else begin
      chip_select_space0_n <= ~cs_nxt; // RL12
      read_strobe_n <= ~(strobe_nxt & ~we_nxt); // RL4 RL9
      low_byte_write_strobe_n <= ~(strobe_nxt & we_nxt); // RL5 RL9
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pins_oe_n <= 1'b0;
      data_oe_n <= 1'b1;
      bus_ack_n <= 1'b1;
    end else begin
      pins_oe_n <= float_nxt; // RL21
      data_oe_n <= ~drive_nxt; // RL10
      bus_ack_n <= ~(state_nxt == cs0_pkg::st_released); // RL16
    end
  end

endmodule // external_cs0_bus_timing

`default_nettype wire

/* sim/cs0_ext_mem.sv */
// Byte memory and stall source on the far side of the space-0 bus.
// Assumes the sequencer's registered outputs on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cs0_ext_mem #(
  parameter int AW = 16,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic [AW-1:0] ext_addr,
  input wire logic chip_select_space0_n,
  input wire logic read_strobe_n,
  input wire logic low_byte_write_strobe_n,
  input wire logic [DW-1:0] data_out,
  input wire logic data_oe_n,
  input wire logic [3:0] stall_len,
  output logic [DW-1:0] data_in,
  output logic stall_n
);
  logic [DW-1:0] mem [256];
  logic [DW-1:0] last = '0;
  logic [3:0] cnt;
  wire logic sel = !chip_select_space0_n;
  wire logic strobe_on = sel && !(read_strobe_n && low_byte_write_strobe_n);
  // ==========================================================================
  // Stall for the first stall_len cycles of each unbroken run of strobe cycles.
  assign stall_n = !(strobe_on && cnt < stall_len);
  // A released bus shows the inverse of its last level.
  assign data_in = !data_oe_n ? data_out :
    (sel && !read_strobe_n) ? mem[ext_addr[7:0]] : ~last;
  always @(posedge clk) begin
    cnt <= strobe_on ? cnt + 4'h1 : 4'h0;
    last <= data_in;
    if (sel && !low_byte_write_strobe_n && !data_oe_n) begin
      mem[ext_addr[7:0]] <= data_out;
    end
  end
endmodule // cs0_ext_mem
`default_nettype wire

/* sim/cs0_props.sv */
// Concurrent checks on the ports of the space-0 bus sequencer.
// Assumes one clock and the register indices of the shared header.
`timescale 1ns/1ps
`default_nettype none
`include "cs0_cfg.svh"
module cs0_props #(
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [2:0] mst_ack,
  input wire logic [2:0] mst_done,
  input wire logic [DW-1:0] mst_rdata,
  input wire logic chip_select_space0_n,
  input wire logic read_strobe_n,
  input wire logic low_byte_write_strobe_n,
  input wire logic pins_oe_n,
  input wire logic [DW-1:0] data_in,
  input wire logic [DW-1:0] data_out,
  input wire logic data_oe_n,
  input wire logic bus_request_n,
  input wire logic bus_ack_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic sw_r;
  logic [3:0] wait_r;
  // ==========================================================================
  // Shadow of the extension bit and wait count.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sw_r <= `ASSERT_EXT_RST;
      wait_r <= `WAIT_FIELD_RST;
    end else if (reg_wr && reg_addr == `REG_IDLE_CFG) begin
      sw_r <= reg_wdata[`SW_BIT];
    end else if (reg_wr && reg_addr == `REG_WAIT_CFG) begin
      wait_r <= reg_wdata[3:0];
    end
  end
  // ==========================================================================
  // Properties.
  property p_rd_cs;
    !read_strobe_n |-> !chip_select_space0_n;
  endproperty
  a_rd_cs: assert property (p_rd_cs)
    else $error("read strobe without select");
  property p_wr_data;
    !low_byte_write_strobe_n |-> !data_oe_n;
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("write without data");
  property p_float;
    !bus_ack_n |-> pins_oe_n;
  endproperty
  a_float: assert property (p_float)
    else $error("pins driven while released");
  property p_ack_cause;
    $fell(bus_ack_n) |-> !$past(bus_request_n);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("acknowledge uncalled");
  property p_rejoin;
    $rose(bus_ack_n) |-> pins_oe_n ##1 !pins_oe_n;
  endproperty
  a_rejoin: assert property (p_rejoin)
    else $error("bad return of the bus");
  property p_two_state;
    !sw_r && wait_r == 4'h0 && (|mst_ack) |-> ##2 (|mst_done);
  endproperty
  a_two_state: assert property (p_two_state)
    else $error("not two states");
  property p_lead;
    sw_r && $fell(chip_select_space0_n) |->
      read_strobe_n && low_byte_write_strobe_n;
  endproperty
  a_lead: assert property (p_lead)
    else $error("strobe in leading state");
  property p_rd_data;
    (|mst_done) && !$past(read_strobe_n) |-> mst_rdata == $past(data_in);
  endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("read byte lost");
  property p_trail;
    $rose(low_byte_write_strobe_n) && read_strobe_n && !chip_select_space0_n
      |-> !data_oe_n && $stable(data_out);
  endproperty
  a_trail: assert property (p_trail)
    else $error("write data not held");
  property p_rsvd;
    reg_rd && reg_addr == `REG_WAIT_CFG |=> reg_rdata[15:4] == 12'hfff;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits not ones");
endmodule // cs0_props
`default_nettype wire

/* sim/external_cs0_bus_timing_tb_top.sv */
// Self-checking bench for the space-0 bus sequencer.
// Assumes the memory model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "cs0_cfg.svh"
module external_cs0_bus_timing_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] mst_req = 3'h0;
  logic [2:0] mst_we = 3'h0;
  logic [47:0] mst_addr = 48'h0;
  logic [23:0] mst_wdata = 24'h0;
  logic bus_request_n = 1'b1;
  logic [3:0] stall_len = 4'h0;
  logic [15:0] reg_rdata, ext_addr;
  logic [2:0] mst_ack, mst_done;
  logic [7:0] mst_rdata, data_in, data_out;
  logic chip_select_space0_n, read_strobe_n, low_byte_write_strobe_n;
  logic pins_oe_n, data_oe_n, stall_n, bus_ack_n;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  external_cs0_bus_timing dut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .mst_req, .mst_we, .mst_addr, .mst_wdata, .mst_ack,
    .mst_done, .mst_rdata, .ext_addr, .chip_select_space0_n, .read_strobe_n,
    .low_byte_write_strobe_n, .pins_oe_n, .data_in, .data_out, .data_oe_n,
    .stall_n, .bus_request_n, .bus_ack_n);
  cs0_ext_mem mem (.clk, .ext_addr, .chip_select_space0_n, .read_strobe_n,
    .low_byte_write_strobe_n, .data_out, .data_oe_n, .stall_len, .data_in,
    .stall_n);
  // ==========================================================================
  // Comparison, verdict and register port tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    check(reg_rdata, e, "reg_rdata");
  endtask
  // ==========================================================================
  // Trace writes, transfer unit reads back, processor writes next byte.
  task automatic run(input int n, input int sw, input int iw, input int cw,
                     input int l, input bit ext);
    int k, dn, len, gap, t, ex;
    logic [7:0] a, d2, d0;
    logic [15:0] icfg;
    k = 0;
    dn = 0;
    len = 0;
    gap = 0;
    t = 0;
    a = 8'($urandom);
    d2 = 8'($urandom);
    d0 = 8'($urandom);
    ex = (n > 0 && l >= n) ? l - n + 1 : 0;
    icfg = 16'hfcee | 16'(iw << 8) | 16'(cw << 4) | 16'(sw);
    reg_write(`REG_WAIT_CFG, 16'hfff0 | 16'(n));
    reg_write(`REG_IDLE_CFG, icfg);
    reg_read(`REG_WAIT_CFG, 16'hfff0 | 16'(n));
    reg_read(`REG_IDLE_CFG, icfg);
    @(posedge clk);
    stall_len <= 4'(l);
    mst_we <= 3'b101;
    mst_addr <= {8'h00, a, 8'h00, a, 8'h00, a + 8'h01};
    mst_wdata <= {d2, 8'h00, d0};
    mst_req <= 3'b111;
    bus_request_n <= !ext;
    while (dn < 3 && t < 400) begin
      @(posedge clk);
      t++;
      len++;
      if (chip_select_space0_n) gap++;
      if (ext && t == 6) begin
        check(bus_ack_n, 1'b0, "bus_ack_n");
        check(k, 0, "grant during release");
        bus_request_n <= 1'b1;
      end
      if (|mst_done) begin
        dn++;
        check(len, (sw ? 3 : 2) + n + ex, "access length");
        if (mst_done[1]) check(mst_rdata, d2, "mst_rdata");
      end
      if (|mst_ack) begin
        check(mst_ack, 3'b100 >> k, "grant order");
        check(ext_addr, {8'h00, a + 8'(k == 2)}, "ext_addr");
        if (k > 0) begin
          check(gap, (k == 1 || cw > iw) ? cw : iw, "idle gap");
        end
        k++;
        gap = 0;
        len = 0;
        mst_req <= mst_req & ~mst_ack;
      end
    end
    check(dn, 3, "done count");
  endtask
  // ==========================================================================
  // Main sequence and hang guard.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    void'($urandom(32'he731));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    reg_read(`REG_WAIT_CFG, 16'hffff);
    reg_read(`REG_IDLE_CFG, 16'hffff);
    reg_read(4'h5, 16'h0000);
    run(0, 0, 0, 0, 3, 1'b1);
    run(0, 1, 1, 0, 0, 1'b0);
    run(0, 0, 2, 0, 0, 1'b0);
    run(1, 1, 2, 1, 2, 1'b0);
    run(2, 0, 3, 1, 3, 1'b0);
    run(15, 0, 0, 1, 0, 1'b0);
    run(2, 1, 3, 0, 0, 1'b1);
    results();
  end
endmodule // external_cs0_bus_timing_tb_top
bind external_cs0_bus_timing cs0_props #(.DW(DW)) u_props (.clk, .nrst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mst_ack, .mst_done,
  .mst_rdata, .chip_select_space0_n, .read_strobe_n, .low_byte_write_strobe_n,
  .pins_oe_n, .data_in, .data_out, .data_oe_n, .bus_request_n, .bus_ack_n);
`default_nettype wire
